// ===== core/commission_pkg.sv
// constants for the commissioning test facility
// assumes a 50 MHz system clock and a 32-bit axi4-lite register slave
package commission_pkg;

   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned LAMP_TIME_MS    = 2000;
   localparam int unsigned LAMP_CYCLES     = (CLK_HZ / 1000) * LAMP_TIME_MS;

   localparam int unsigned NUM_INPUTS      = 16;
   localparam int unsigned NUM_OUTPUTS     = 16;
   localparam int unsigned NUM_PROBES      = 8;
   localparam int unsigned NUM_LAMPS       = 8;
   localparam int unsigned SEL_W           = 10;
   localparam int unsigned BUS_SIGNALS     = 1024;
   localparam logic [9:0]  SEL_MAX         = 10'h3_FE;
   localparam logic [9:0]  SEL_DEFAULT0    = 10'h0_40;

   // register byte offsets
   localparam logic [7:0] OFS_INPUT_VIEW   = 8'h00;
   localparam logic [7:0] OFS_OUTPUT_VIEW  = 8'h04;
   localparam logic [7:0] OFS_PROBE_VIEW   = 8'h08;
   localparam logic [7:0] OFS_INDICATOR    = 8'h0C;
   localparam logic [7:0] OFS_SEL_BASE     = 8'h10;
   localparam logic [7:0] OFS_MODE         = 8'h30;
   localparam logic [7:0] OFS_PATTERN      = 8'h34;
   localparam logic [7:0] OFS_CONTACT_CMD  = 8'h38;
   localparam logic [7:0] OFS_LAMP_CMD     = 8'h3C;
   localparam logic [7:0] OFS_IRQ_STATUS   = 8'h40;
   localparam logic [7:0] OFS_IRQ_MASK     = 8'h44;
   localparam logic [7:0] OFS_CAUSE        = 8'h48;

   // command encodings
   localparam logic [1:0] CMD_IDLE         = 2'h0;
   localparam logic [1:0] CMD_APPLY        = 2'h1;
   localparam logic [1:0] CMD_REMOVE       = 2'h2;

   // transmission cause values
   localparam logic [7:0] CAUSE_NORMAL     = 8'h01;
   localparam logic [7:0] CAUSE_TEST       = 8'h07;

   // irq status bit positions
   localparam int unsigned IRQ_MAINT_ENTER = 0;
   localparam int unsigned IRQ_MAINT_EXIT  = 1;
   localparam int unsigned IRQ_LAMP_DONE   = 2;
   localparam int unsigned IRQ_W           = 3;

   localparam logic [1:0] RESP_OKAY        = 2'h0;
   localparam logic [1:0] RESP_SLVERR      = 2'h2;

   typedef enum logic [1:0]
   {
      MODE_DISABLED = 2'b00,
      MODE_MAINT    = 2'b01,
      MODE_BLOCKED  = 2'b10
   } mode_t;

   typedef enum logic [0:0]
   {
      LAMP_IDLE = 1'b0,
      LAMP_RUN  = 1'b1
   } lamp_state_t;

endpackage : commission_pkg

// ===== core/commission_test.sv
// commissioning test facility: status views, probes, maintenance mode,
// contact exercise and timed lamp check behind an axi4-lite slave
// assumes scheme, lamp and bus inputs are on clk; isolated inputs are async
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - input view, one bit per input
// - output view shows scheme drive bits
// - view shows scheme drive even when blocked
// - probe view holds eight selected bus bits
// - eight-bit lamp view, 1 means lit
// - selectors 0..1022, defaults 64..71
// - each probe drives own monitor pin
// - maintenance: out of service and alarm
// - blocked mode also zeroes scheme drive; exercise pattern still applied
// - disabled restores service; reset default disabled
// - maintenance input also enters maintenance
// - maintenance switches transmission cause to test
// - pattern one bit per output, resets zero
// - apply toggles patterned outputs unless lamp check runs, command idles
// - test state held until remove
// - remove restores normal drive unless lamp check runs, command idles
// - lamp check lights all lamps ~2 s
module commission_test #(
   parameter int unsigned LAMP_CYCLES = commission_pkg::LAMP_CYCLES
) (
   input  wire logic                                     clk,
   input  wire logic                                     rst,
   input  wire logic [commission_pkg::NUM_INPUTS-1:0]    input_pins,
   input  wire logic                                     maint_input,
   input  wire logic [commission_pkg::NUM_OUTPUTS-1:0]   scheme_drive,
   input  wire logic [commission_pkg::BUS_SIGNALS-1:0]   internal_signal_bus,
   input  wire logic [commission_pkg::NUM_LAMPS-1:0]     user_lamps,
   output logic      [commission_pkg::NUM_OUTPUTS-1:0]   relay_drive,
   output logic      [commission_pkg::NUM_LAMPS-1:0]     lamp_drive,
   output logic      [commission_pkg::NUM_PROBES-1:0]    monitor_port,
   output logic                                          out_of_service,
   output logic                                          alarm,
   output logic      [7:0]                               transmission_cause,
   output logic                                          irq,
   input  wire logic [7:0]                               s_axi_awaddr,
   input  wire logic                                     s_axi_awvalid,
   output logic                                          s_axi_awready,
   input  wire logic [31:0]                              s_axi_wdata,
   input  wire logic [3:0]                               s_axi_wstrb,
   input  wire logic                                     s_axi_wvalid,
   output logic                                          s_axi_wready,
   output logic      [1:0]                               s_axi_bresp,
   output logic                                          s_axi_bvalid,
   input  wire logic                                     s_axi_bready,
   input  wire logic [7:0]                               s_axi_araddr,
   input  wire logic                                     s_axi_arvalid,
   output logic                                          s_axi_arready,
   output logic      [31:0]                              s_axi_rdata,
   output logic      [1:0]                               s_axi_rresp,
   output logic                                          s_axi_rvalid,
   input  wire logic                                     s_axi_rready
);

   localparam int unsigned NI = commission_pkg::NUM_INPUTS;
   localparam int unsigned NO = commission_pkg::NUM_OUTPUTS;
   localparam int unsigned NP = commission_pkg::NUM_PROBES;
   localparam int unsigned NL = commission_pkg::NUM_LAMPS;
   localparam int unsigned SW = commission_pkg::SEL_W;
   localparam int unsigned TW = $clog2(LAMP_CYCLES + 1);
   localparam logic [TW-1:0] LAMP_LAST = TW'(LAMP_CYCLES - 1);
   localparam int unsigned IRQ_W_L = commission_pkg::IRQ_W;

   typedef struct packed
   {
      logic [NI-1:0]                  in_meta;
      logic [NI-1:0]                  in_sync;
      logic                           maint_meta;
      logic                           maint_sync;
      logic [NP-1:0][SW-1:0]          sel;
      commission_pkg::mode_t          mode;
      logic [NO-1:0]                  pattern;
      logic                           exercising;
      commission_pkg::lamp_state_t    lamp_state;
      logic [TW-1:0]                  lamp_count;
      logic [NP-1:0]                  probe;
      logic [NO-1:0]                  drive;
      logic [NL-1:0]                  lamps;
      logic                           in_maint;
      logic [IRQ_W_L-1:0]             irq_status;
      logic [IRQ_W_L-1:0]             irq_mask;
      logic                           aw_held;
      logic [7:0]                     aw_addr;
      logic                           w_held;
      logic [31:0]                    w_data;
      logic [3:0]                     w_strb;
      logic                           bvalid;
      logic [1:0]                     bresp;
      logic                           rvalid;
      logic [31:0]                    rdata;
      logic [1:0]                     rresp;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // selector register index from a byte address, or NP when not a selector
   function automatic logic [3:0] sel_index(input logic [7:0] addr);
      logic [7:0] rel;
      rel = addr - commission_pkg::OFS_SEL_BASE;
      if (addr >= commission_pkg::OFS_SEL_BASE && rel < 8'(NP * 4) && rel[1:0] == 2'b00)
         sel_index = rel[5:2];
      else
         sel_index = 4'(NP);
   endfunction : sel_index

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            res[b*8 +: 8] = data[b*8 +: 8];
      merge = res;
   endfunction : merge

   function automatic state_t reset_state();
      state_t s;
      s = '0;
      for (int i = 0; i < NP; i++)
         s.sel[i] = commission_pkg::SEL_DEFAULT0 + SW'(i);
      s.mode = commission_pkg::MODE_DISABLED;
      s.lamp_state = commission_pkg::LAMP_IDLE;
      s.bresp = commission_pkg::RESP_OKAY;
      s.rresp = commission_pkg::RESP_OKAY;
      reset_state = s;
   endfunction : reset_state

   // evaluated once at elaboration so the reset branch loads a constant
   localparam state_t RESET_STATE = reset_state();

   always_comb
   begin
      logic          do_write;
      logic          do_read;
      logic [31:0]   wval;
      logic [31:0]   cur;
      logic [3:0]    widx;
      logic [3:0]    ridx;
      logic          apply_cmd;
      logic          remove_cmd;
      logic          lamp_cmd;
      logic          blocked;
      logic          lamp_busy;
      logic [IRQ_W_L-1:0] events;
      logic [IRQ_W_L-1:0] w1c;
      do_write   = 1'b0;
      do_read    = 1'b0;
      wval       = 32'h0000_0000;
      cur        = 32'h0000_0000;
      widx       = 4'h0;
      ridx       = 4'h0;
      apply_cmd  = 1'b0;
      remove_cmd = 1'b0;
      lamp_cmd   = 1'b0;
      blocked    = 1'b0;
      lamp_busy  = 1'b0;
      events     = '0;
      w1c        = '0;
      state_next = state_reg;

      state_next.in_meta    = input_pins;
      state_next.in_sync    = state_reg.in_meta;
      state_next.maint_meta = maint_input;
      state_next.maint_sync = state_reg.maint_meta;

      // write channel capture, either order
      if (s_axi_awvalid && !state_reg.aw_held)
      begin
         state_next.aw_held = 1'b1;
         state_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !state_reg.w_held)
      begin
         state_next.w_held = 1'b1;
         state_next.w_data = s_axi_wdata;
         state_next.w_strb = s_axi_wstrb;
      end
      lamp_busy = (state_reg.lamp_state == commission_pkg::LAMP_RUN);
      do_write  = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
      if (do_write)
      begin
         state_next.aw_held = 1'b0;
         state_next.w_held  = 1'b0;
         state_next.bvalid  = 1'b1;
         state_next.bresp   = commission_pkg::RESP_OKAY;
         widx = sel_index(state_reg.aw_addr);
         wval = state_reg.w_data;
         if (widx != 4'(NP))
         begin
            cur = merge(32'(state_reg.sel[widx[2:0]]), wval, state_reg.w_strb);
            if (cur[SW-1:0] <= commission_pkg::SEL_MAX)
               state_next.sel[widx[2:0]] = cur[SW-1:0];
            else
               state_next.bresp = commission_pkg::RESP_SLVERR;
         end
         else
            case (state_reg.aw_addr)
               commission_pkg::OFS_MODE:
               begin
                  cur = merge(32'(state_reg.mode), wval, state_reg.w_strb);
                  if (cur[1:0] == 2'b11)
                     state_next.bresp = commission_pkg::RESP_SLVERR;
                  else
                     state_next.mode = commission_pkg::mode_t'(cur[1:0]);
               end
               commission_pkg::OFS_PATTERN:
                  state_next.pattern = NO'(merge(32'(state_reg.pattern), wval, state_reg.w_strb));
               commission_pkg::OFS_CONTACT_CMD:
               begin
                  // the command cell always reads idle, so a write is a pulse
                  apply_cmd  = state_reg.w_strb[0] && wval[1:0] == commission_pkg::CMD_APPLY && !lamp_busy;
                  remove_cmd = state_reg.w_strb[0] && wval[1:0] == commission_pkg::CMD_REMOVE && !lamp_busy;
               end
               commission_pkg::OFS_LAMP_CMD:
                  lamp_cmd = state_reg.w_strb[0] && wval[1:0] == commission_pkg::CMD_APPLY && !lamp_busy;
               commission_pkg::OFS_IRQ_STATUS:
                  w1c = IRQ_W_L'(merge(32'h0000_0000, wval, state_reg.w_strb));
               commission_pkg::OFS_IRQ_MASK:
                  state_next.irq_mask = IRQ_W_L'(merge(32'(state_reg.irq_mask), wval, state_reg.w_strb));
               commission_pkg::OFS_INPUT_VIEW, commission_pkg::OFS_OUTPUT_VIEW,
               commission_pkg::OFS_PROBE_VIEW, commission_pkg::OFS_INDICATOR,
               commission_pkg::OFS_CAUSE:
                  ;
               default:
                  state_next.bresp = commission_pkg::RESP_SLVERR;
            endcase
      end
      if (state_reg.bvalid && s_axi_bready)
         state_next.bvalid = 1'b0;

      // read channel
      do_read = s_axi_arvalid && !state_reg.rvalid;
      if (do_read)
      begin
         state_next.rvalid = 1'b1;
         state_next.rresp  = commission_pkg::RESP_OKAY;
         state_next.rdata  = 32'h0000_0000;
         ridx = sel_index(s_axi_araddr);
         if (ridx != 4'(NP))
            state_next.rdata = 32'(state_reg.sel[ridx[2:0]]);
         else
            case (s_axi_araddr)
               commission_pkg::OFS_INPUT_VIEW:  state_next.rdata = 32'(state_reg.in_sync);
               commission_pkg::OFS_OUTPUT_VIEW: state_next.rdata = 32'(scheme_drive);
               commission_pkg::OFS_PROBE_VIEW:  state_next.rdata = 32'(state_reg.probe);
               commission_pkg::OFS_INDICATOR:   state_next.rdata = 32'(state_reg.lamps);
               commission_pkg::OFS_MODE:        state_next.rdata = 32'(state_reg.mode);
               commission_pkg::OFS_PATTERN:     state_next.rdata = 32'(state_reg.pattern);
               commission_pkg::OFS_CONTACT_CMD: state_next.rdata = 32'(commission_pkg::CMD_IDLE);
               commission_pkg::OFS_LAMP_CMD:    state_next.rdata = 32'(commission_pkg::CMD_IDLE);
               commission_pkg::OFS_IRQ_STATUS:  state_next.rdata = 32'(state_reg.irq_status);
               commission_pkg::OFS_IRQ_MASK:    state_next.rdata = 32'(state_reg.irq_mask);
               commission_pkg::OFS_CAUSE:       state_next.rdata = 32'(transmission_cause);
               default:                         state_next.rresp = commission_pkg::RESP_SLVERR;
            endcase
      end
      if (state_reg.rvalid && s_axi_rready)
         state_next.rvalid = 1'b0;

      // probes sample the bus every cycle
      for (int i = 0; i < NP; i++)
         state_next.probe[i] = internal_signal_bus[state_reg.sel[i]];

      // maintenance: setting or mapped input
      state_next.in_maint = (state_reg.mode != commission_pkg::MODE_DISABLED) || state_reg.maint_sync;
      blocked = (state_reg.mode == commission_pkg::MODE_BLOCKED);

      // contact exercise
      if (apply_cmd)
         state_next.exercising = 1'b1;
      else if (remove_cmd)
         state_next.exercising = 1'b0;
      if (state_reg.exercising)
         state_next.drive = (blocked ? '0 : scheme_drive) ^ state_reg.pattern;
      else
         state_next.drive = blocked ? '0 : scheme_drive;

      // lamp check timer
      case (state_reg.lamp_state)
         commission_pkg::LAMP_IDLE:
         begin
            state_next.lamps = user_lamps;
            if (lamp_cmd)
            begin
               state_next.lamp_state = commission_pkg::LAMP_RUN;
               state_next.lamp_count = '0;
               state_next.lamps      = '1;
            end
         end
         commission_pkg::LAMP_RUN:
         begin
            state_next.lamps = '1;
            if (state_reg.lamp_count == LAMP_LAST)
            begin
               state_next.lamp_state = commission_pkg::LAMP_IDLE;
               state_next.lamps      = user_lamps;
               events[commission_pkg::IRQ_LAMP_DONE] = 1'b1;
            end
            else
               state_next.lamp_count = state_reg.lamp_count + TW'(1);
         end
         default:
            state_next.lamp_state = commission_pkg::LAMP_IDLE;
      endcase

      events[commission_pkg::IRQ_MAINT_ENTER] = state_next.in_maint && !state_reg.in_maint;
      events[commission_pkg::IRQ_MAINT_EXIT]  = !state_next.in_maint && state_reg.in_maint;
      // a new event beats a same-cycle clear
      state_next.irq_status = (state_reg.irq_status & ~w1c) | events;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state_reg <= RESET_STATE;
      else
         state_reg <= state_next;
   end

   assign relay_drive        = state_reg.drive;
   assign lamp_drive         = state_reg.lamps;
   assign monitor_port       = state_reg.probe;
   assign out_of_service     = state_reg.in_maint;
   assign alarm              = state_reg.in_maint;
   assign transmission_cause = state_reg.in_maint ? commission_pkg::CAUSE_TEST
                                                  : commission_pkg::CAUSE_NORMAL;
   assign irq                = |(state_reg.irq_status & state_reg.irq_mask);
   assign s_axi_awready      = !state_reg.aw_held;
   assign s_axi_wready       = !state_reg.w_held;
   assign s_axi_bvalid       = state_reg.bvalid;
   assign s_axi_bresp        = state_reg.bresp;
   assign s_axi_arready      = !state_reg.rvalid;
   assign s_axi_rvalid       = state_reg.rvalid;
   assign s_axi_rdata        = state_reg.rdata;
   assign s_axi_rresp        = state_reg.rresp;

endmodule : commission_test

`default_nettype wire

// ===== tb/commission_test_sva.sv
// port-level assertions for the commissioning test facility
// assumes one clock, async active-high reset, bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module commission_test_sva #(
   parameter int unsigned LAMP_CYCLES = 20
) (
   input wire logic                                  clk,
   input wire logic                                  rst,
   input wire logic                                  maint_input,
   input wire logic [commission_pkg::NUM_LAMPS-1:0]  user_lamps,
   input wire logic [commission_pkg::NUM_LAMPS-1:0]  lamp_drive,
   input wire logic                                  out_of_service,
   input wire logic                                  alarm,
   input wire logic [7:0]                            transmission_cause,
   input wire logic                                  s_axi_awvalid,
   input wire logic                                  s_axi_awready,
   input wire logic                                  s_axi_wvalid,
   input wire logic                                  s_axi_wready,
   input wire logic [1:0]                            s_axi_bresp,
   input wire logic                                  s_axi_bvalid,
   input wire logic                                  s_axi_bready,
   input wire logic                                  s_axi_arvalid,
   input wire logic                                  s_axi_arready,
   input wire logic [31:0]                           s_axi_rdata,
   input wire logic [1:0]                            s_axi_rresp,
   input wire logic                                  s_axi_rvalid,
   input wire logic                                  s_axi_rready
);
   int unsigned lamp_cnt;
   logic [7:0]  prev_lamps;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // user lamps already all lit are not counted as a lamp check
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         lamp_cnt   <= 0;
         prev_lamps <= 8'h00;
      end
      else
      begin
         prev_lamps <= user_lamps;
         lamp_cnt   <= (lamp_drive == 8'hFF && prev_lamps != 8'hFF) ? lamp_cnt + 1 : 0;
      end
   end

   chk_alarm_tracks: assert property (alarm == out_of_service)
      else $error("alarm differs from out of service");
   chk_cause_test: assert property ($rose(out_of_service) |-> ##[0:2] transmission_cause == 8'h07)
      else $error("cause not test value in maintenance");
   chk_cause_normal: assert property ($fell(out_of_service) |-> ##[0:2] transmission_cause == 8'h01)
      else $error("cause not normal after maintenance");
   chk_lamp_source: assert property (!$past(rst) && lamp_drive != $past(user_lamps) |-> lamp_drive == 8'hFF)
      else $error("lamp drive neither user lamps nor all lit");
   chk_lamp_length: assert property (lamp_cnt <= LAMP_CYCLES + 2)
      else $error("lamp check ran too long");
   chk_maint_pin: assert property (maint_input [*5] |-> out_of_service)
      else $error("maintenance input ignored");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp}))
      else $error("read data dropped early");
   chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                                       && !s_axi_bvalid |-> ##[2:3] s_axi_bvalid)
      else $error("write answer late");
   chk_arready_free: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("arready not inverse of rvalid");

   cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
   cover property (lamp_cnt == LAMP_CYCLES);
   cover property ($rose(out_of_service));
endmodule : commission_test_sva
`default_nettype wire

// ===== tb/commission_test_test.sv
// self-checking bench for the commissioning test facility
// assumes a 50 MHz clock, an axi4-lite master in tasks, a shortened lamp timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module commission_test_test;
   localparam int unsigned LAMP = 20;
   localparam logic [1:0]  OK   = commission_pkg::RESP_OKAY;
   localparam logic [1:0]  ERR  = commission_pkg::RESP_SLVERR;
   typedef struct packed {logic [15:0] inp; logic [15:0] drv; logic [7:0] lmp; logic [7:0] prb;} row_t;
   // every view echoes its source, so each field is stimulus and expectation
   row_t rows [3] = '{'{16'hA5C3, 16'h1234, 8'h81, 8'h5A}, '{16'h0000, 16'hFFFF, 8'h00, 8'hFF},
                      '{16'hFFFF, 16'h0000, 8'h7E, 8'h00}};
   logic          clk = 1'b0, rst = 1'b1, maint_input = 1'b0;
   logic [15:0]   input_pins = 16'h0000, scheme_drive = 16'h0000, relay_drive;
   logic [1023:0] internal_signal_bus = '0;
   logic [7:0]    user_lamps = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [7:0]    lamp_drive, monitor_port, transmission_cause;
   logic [31:0]   s_axi_wdata = 32'h0000_0000, s_axi_rdata;
   logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic          out_of_service, alarm, irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]    s_axi_bresp, s_axi_rresp;
   int            miscompares = 0, tests_run = 0, cycles = 0;

   commission_test #(.LAMP_CYCLES(LAMP)) i_commission_test (.clk, .rst, .input_pins, .maint_input, .scheme_drive,
      .internal_signal_bus, .user_lamps, .relay_drive, .lamp_drive, .monitor_port, .out_of_service, .alarm,
      .transmission_cause, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   always #10 clk = ~clk;

   task automatic tally_and_finish();
      if (miscompares == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   // run needs a few hundred cycles; the ceiling only catches a hang
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         miscompares++;
         tally_and_finish();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // both channels offered together, each released when taken
   task automatic chk_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      `CHK(s_axi_bresp, er);
   endtask : chk_wr

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      `CHK(s_axi_rresp, er);
      `CHK(s_axi_rdata, ed);
   endtask : chk_rd

   initial
   begin
      tick(3);
      rst <= 1'b0;
      foreach (rows[i])
      begin
         input_pins                 <= rows[i].inp;
         scheme_drive               <= rows[i].drv;
         user_lamps                 <= rows[i].lmp;
         internal_signal_bus[71:64] <= rows[i].prb;
         tick(4);
         `CHK(monitor_port, rows[i].prb);
         `CHK(lamp_drive, rows[i].lmp);
         chk_rd(8'h00, {16'h0000, rows[i].inp}, OK);
         chk_rd(8'h04, {16'h0000, rows[i].drv}, OK);
         chk_rd(8'h08, {24'h00_0000, rows[i].prb}, OK);
         chk_rd(8'h0C, {24'h00_0000, rows[i].lmp}, OK);
      end
      internal_signal_bus[1022] <= 1'b1;
      chk_wr(8'h10, 32'h0000_03FE, OK);
      tick(3);
      `CHK(monitor_port, 8'h01);
      chk_rd(8'h08, 32'h0000_0001, OK);
      chk_wr(8'h10, 32'h0000_03FF, ERR);
      chk_rd(8'h10, 32'h0000_03FE, OK);
      scheme_drive <= 16'h00F0;
      chk_wr(8'h34, 32'h0000_0F0F, OK);
      chk_rd(8'h34, 32'h0000_0F0F, OK);
      chk_wr(8'h3C, 32'h0000_0001, OK);
      tick(2);
      `CHK(lamp_drive, 8'hFF);
      chk_wr(8'h38, 32'h0000_0001, OK);
      tick(2);
      `CHK(relay_drive, 16'h00F0);
      chk_rd(8'h3C, 32'h0000_0000, OK);
      `CHK(lamp_drive, 8'hFF);
      tick(LAMP);
      `CHK(lamp_drive, 8'h7E);
      `CHK(irq, 1'b0);
      chk_rd(8'h40, 32'h0000_0004, OK);
      chk_wr(8'h44, 32'h0000_0004, OK);
      tick(2);
      `CHK(irq, 1'b1);
      chk_wr(8'h40, 32'h0000_0004, OK);
      tick(2);
      `CHK(irq, 1'b0);
      chk_rd(8'h40, 32'h0000_0000, OK);
      chk_wr(8'h38, 32'h0000_0001, OK);
      tick(3);
      `CHK(relay_drive, 16'h0FFF);
      chk_rd(8'h38, 32'h0000_0000, OK);
      chk_wr(8'h38, 32'h0000_0000, OK);
      tick(3);
      `CHK(relay_drive, 16'h0FFF);
      chk_wr(8'h38, 32'h0000_0002, OK);
      tick(3);
      `CHK(relay_drive, 16'h00F0);
      chk_rd(8'h38, 32'h0000_0000, OK);
      chk_wr(8'h30, 32'h0000_0001, OK);
      tick(3);
      `CHK(out_of_service, 1'b1);
      `CHK(alarm, 1'b1);
      `CHK(relay_drive, 16'h00F0);
      `CHK(transmission_cause, 8'h07);
      chk_wr(8'h30, 32'h0000_0002, OK);
      tick(3);
      `CHK(relay_drive, 16'h0000);
      `CHK(out_of_service, 1'b1);
      chk_rd(8'h04, 32'h0000_00F0, OK);
      chk_wr(8'h30, 32'h0000_0003, ERR);
      chk_wr(8'h30, 32'h0000_0000, OK);
      tick(3);
      `CHK(out_of_service, 1'b0);
      `CHK(relay_drive, 16'h00F0);
      chk_rd(8'h48, 32'h0000_0001, OK);
      maint_input <= 1'b1;
      tick(6);
      `CHK(out_of_service, 1'b1);
      `CHK(transmission_cause, 8'h07);
      maint_input <= 1'b0;
      tick(6);
      `CHK(out_of_service, 1'b0);
      chk_rd(8'h40, 32'h0000_0003, OK);
      chk_rd(8'h80, 32'h0000_0000, ERR);
      chk_wr(8'h84, 32'h0000_0001, ERR);
      rst <= 1'b1;
      tick(3);
      rst <= 1'b0;
      chk_rd(8'h10, 32'h0000_0040, OK);
      chk_rd(8'h2C, 32'h0000_0047, OK);
      chk_rd(8'h30, 32'h0000_0000, OK);
      chk_rd(8'h34, 32'h0000_0000, OK);
      tally_and_finish();
   end
endmodule : commission_test_test

bind commission_test commission_test_sva #(.LAMP_CYCLES(LAMP_CYCLES)) i_commission_test_sva (.clk, .rst,
   .maint_input, .user_lamps, .lamp_drive, .out_of_service, .alarm, .transmission_cause, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire
